// ---- logic/power_telemetry_i2c_slave.sv ----
module power_telemetry_i2c_slave
  import telemetry_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic i_scl,
  input wire logic i_serial_line_sda,
  output logic o_serial_line_sda,
  output logic o_serial_line_sda_oe_n,
  input wire logic [ADDR_VAR_W-1:0] i_addr_strap,
  input wire logic i_feed_a_on_input,
  input wire logic i_feed_b_on_input,
  input wire logic i_fault_alarm,
  input wire logic i_cap_connected,
  input wire logic i_hotswap_on,
  input wire logic i_main_output_ok,
  input wire logic i_meas_clk,
  input wire logic i_meas_resetn,
  input wire logic [7:0] i_holdup_voltage,
  input wire logic [7:0] i_output_current,
  input wire logic [7:0] i_feed_a_voltage,
  input wire logic [7:0] i_feed_b_voltage,
  input wire logic [7:0] i_module_heat_reading
);
  // measurement domain: snapshot words handed over by toggle handshake
  logic [39:0] meas_hold_r; // held stable while a handover is open
  logic meas_req_r; // request toggle, meas domain
  wire meas_ack_s; // ack toggle seen in meas domain
  wire req_s; // request toggle seen in bus domain
  logic ack_r; // ack toggle, bus domain
  logic [39:0] shadow_r; // bus-domain copy of the readings

  // bus-domain synchronised pins
  wire [1:0] line_s; // {scl, sda}
  wire [8:0] pins_s; // {strap, status pins}
  wire scl_s;
  wire sda_s;
  logic scl_d_r; // previous synchronised scl
  logic sda_d_r; // previous synchronised sda
  wire scl_rise;
  wire scl_fall;
  wire start_det;
  wire stop_det;
  wire [ADDR_VAR_W-1:0] strap_s;
  wire addr_hit;
  wire [7:0] rd_data;

  // link state and its next values
  link_state_t state_r;
  link_state_t state_nxt;
  logic [3:0] cnt_r; // bits handled in the current byte
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r; // incoming byte
  logic [7:0] shift_nxt;
  logic [7:0] tx_r; // outgoing byte, msb on the line
  logic [7:0] tx_nxt;
  logic [7:0] ptr_r; // register pointer
  logic [7:0] ptr_nxt;
  logic rw_r; // read flag of the last address byte
  logic rw_nxt;
  logic oe_n_r; // low pulls sda low
  logic oe_n_nxt;
  logic sda_o_r; // value put on sda, always low

  // the meas side only opens a new handover once the last one is acked
  always_ff @(posedge i_meas_clk)
  begin
    if (!i_meas_resetn)
    begin
      meas_hold_r <= '0;
      meas_req_r <= 1'b0;
    end
    else if (meas_req_r == meas_ack_s)
    begin
      meas_hold_r <= {i_holdup_voltage, i_output_current, i_feed_a_voltage,
                      i_feed_b_voltage, i_module_heat_reading};
      meas_req_r <= ~meas_req_r;
    end
  end

  // ack toggle back into the meas domain
  bit_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_ack_sync (
    .i_clk(i_meas_clk),
    .i_resetn(i_meas_resetn),
    .i_ce(1'b1),
    .i_async(ack_r),
    .o_sync(meas_ack_s)
  );

  // request toggle into the bus domain
  bit_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async(meas_req_r),
    .o_sync(req_s)
  );

  // copy the held words once the request is seen; they settled two edges ago
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      shadow_r <= '0;
      ack_r <= 1'b0;
    end
    else if (i_ce && (req_s != ack_r))
    begin
      shadow_r <= meas_hold_r;
      ack_r <= req_s;
    end
  end

  // bus lines idle high, so they reset high to avoid a false start
  bit_sync #(.WIDTH(2), .RESET_VAL(2'b11)) u_line_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({i_scl, i_serial_line_sda}),
    .o_sync(line_s)
  );

  // strap and status pins are slow levels
  bit_sync #(.WIDTH(9), .RESET_VAL(9'h000)) u_pin_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_async({i_addr_strap, i_main_output_ok, i_hotswap_on, i_cap_connected,
              i_fault_alarm, i_feed_b_on_input, i_feed_a_on_input}),
    .o_sync(pins_s)
  );

  assign scl_s = line_s[1];
  assign sda_s = line_s[0];
  assign strap_s = pins_s[8:6];

  // edge history of the bus lines
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else if (i_ce)
    begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // the master owns the clock; we only watch its edges
  assign scl_rise = scl_s & ~scl_d_r;
  assign scl_fall = ~scl_s & scl_d_r;
  // sda moving while scl is high marks start or stop
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;
  // fixed nibble plus strap bits, read flag is bit 0
  assign addr_hit = (shift_r[7:1] == {ADDR_FIXED, strap_s});

  // read map from the bus-domain copy
  telemetry_regmap u_regmap (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_ptr(ptr_r),
    .i_status_pins(pins_s[5:0]),
    .i_holdup_voltage(shadow_r[39:32]),
    .i_output_current(shadow_r[31:24]),
    .i_feed_a_voltage(shadow_r[23:16]),
    .i_feed_b_voltage(shadow_r[15:8]),
    .i_module_heat_reading(shadow_r[7:0]),
    .o_rd_data(rd_data)
  );

  // link sequencer; sda only changes after a falling scl edge
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    oe_n_nxt = oe_n_r;
    if (stop_det)
    begin
      // stop ends any transfer and frees the line
      state_nxt = ST_IDLE;
      oe_n_nxt = 1'b1;
    end
    else if (start_det)
    begin
      // start or repeated start always begins an address byte
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_n_nxt = 1'b1;
    end
    else
    begin
      case (state_r)
        ST_ADDR, ST_PTR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_nxt = {shift_r[6:0], sda_s};
            cnt_nxt = cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == BYTE_BITS)
          begin
            oe_n_nxt = 1'b0; // acknowledge by pulling low
            if (state_r == ST_ADDR)
            begin
              if (addr_hit)
              begin
                state_nxt = ST_ADDR_ACK;
                rw_nxt = shift_r[0];
              end
              else
              begin
                // someone else's address: stay off the line
                state_nxt = ST_IGNORE;
                oe_n_nxt = 1'b1;
              end
            end
            else if (state_r == ST_PTR)
            begin
              ptr_nxt = shift_r;
              state_nxt = ST_PTR_ACK;
            end
            else
              state_nxt = ST_WDATA_ACK;
          end
        end
        ST_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            cnt_nxt = 4'h0;
            if (rw_r)
            begin
              // present msb of the pointed byte
              state_nxt = ST_RDATA;
              tx_nxt = rd_data;
              oe_n_nxt = rd_data[7];
            end
            else
            begin
              state_nxt = ST_PTR;
              oe_n_nxt = 1'b1;
            end
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK:
        begin
          // further write bytes are acked and dropped
          if (scl_fall)
          begin
            state_nxt = ST_WDATA;
            cnt_nxt = 4'h0;
            oe_n_nxt = 1'b1;
          end
        end
        ST_RDATA:
        begin
          if (scl_fall)
          begin
            if (cnt_r == LAST_BIT)
            begin
              // release for the master's acknowledge
              state_nxt = ST_RACK;
              oe_n_nxt = 1'b1;
            end
            else
            begin
              tx_nxt = {tx_r[6:0], 1'b1};
              oe_n_nxt = tx_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        ST_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_s)
              state_nxt = ST_IGNORE; // not acked: wait for stop
            else
              cnt_nxt = BYTE_BITS; // acked: send again at next fall
          end
          else if (scl_fall && cnt_r == BYTE_BITS)
          begin
            // pointer does not advance: the same register repeats
            state_nxt = ST_RDATA;
            tx_nxt = rd_data;
            oe_n_nxt = rd_data[7];
            cnt_nxt = 4'h0;
          end
        end
        default:
        begin
          // idle and ignore wait for start or stop
          state_nxt = state_r;
        end
      endcase
    end
  end

  // link state registers
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= PTR_RESET;
      rw_r <= 1'b0;
      oe_n_r <= 1'b1;
    end
    else if (i_ce)
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // the driven level is always low; only the enable moves
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      sda_o_r <= 1'b0;
    else if (i_ce)
      sda_o_r <= 1'b0;
  end

  // no scl output exists: the target never clocks the bus
  assign o_serial_line_sda = sda_o_r;
  assign o_serial_line_sda_oe_n = oe_n_r;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  chk_drive_only_ack: assert property (
    !o_serial_line_sda_oe_n |-> state_r inside {ST_ADDR_ACK, ST_PTR_ACK,
      ST_WDATA_ACK, ST_RDATA})
    else $error("sda pulled outside ack or read");
  chk_pull_low_only: assert property (
    !o_serial_line_sda_oe_n |-> o_serial_line_sda == 1'b0)
    else $error("sda driven high");
  chk_addr_match: assert property (
    i_ce && !stop_det && !start_det && state_r == ST_ADDR && scl_fall
      && cnt_r == BYTE_BITS && shift_r[7:1] == {ADDR_FIXED, strap_s}
      |=> state_r == ST_ADDR_ACK && !o_serial_line_sda_oe_n)
    else $error("own address not acknowledged");
  chk_addr_miss: assert property (
    i_ce && !stop_det && !start_det && state_r == ST_ADDR && scl_fall
      && cnt_r == BYTE_BITS && shift_r[7:1] != {ADDR_FIXED, strap_s}
      |=> state_r == ST_IGNORE && o_serial_line_sda_oe_n)
    else $error("foreign address acknowledged");
  chk_pointer_load: assert property (
    i_ce && !stop_det && !start_det && state_r == ST_PTR && scl_fall
      && cnt_r == BYTE_BITS |=> ptr_r == $past(shift_r))
    else $error("pointer not captured");
  chk_stop_idle: assert property (
    i_ce && stop_det |=> state_r == ST_IDLE ##1 o_serial_line_sda_oe_n)
    else $error("stop not honoured");
  chk_write_ignored: assert property (
    state_r inside {ST_WDATA, ST_WDATA_ACK} |=> $stable(ptr_r))
    else $error("data write altered pointer");
  chk_read_bit: assert property (
    state_r == ST_RDATA |-> o_serial_line_sda_oe_n == tx_r[7])
    else $error("read bit differs from byte");
endmodule : power_telemetry_i2c_slave

// ---- pkg/telemetry_pkg.sv ----
package telemetry_pkg;
  // fixed upper part of the seven-bit target address
  localparam logic [3:0] ADDR_FIXED = 4'h5;
  // width of the strap-selected address part
  localparam int ADDR_VAR_W = 3;
  // bits in a byte and the count value of a complete byte
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;
  // pointer values of the read-only map
  localparam logic [7:0] PTR_STATUS = 8'h1E;
  localparam logic [7:0] PTR_HOLDUP = 8'h1F;
  localparam logic [7:0] PTR_CURRENT = 8'h21;
  localparam logic [7:0] PTR_FEED_A = 8'h22;
  localparam logic [7:0] PTR_FEED_B = 8'h23;
  localparam logic [7:0] PTR_HEAT = 8'h28;
  // pointer after reset
  localparam logic [7:0] PTR_RESET = 8'h1E;
  // answer to a pointer outside the map
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;
  // status byte field positions
  localparam int BIT_FEED_A = 0;
  localparam int BIT_FEED_B = 1;
  localparam int BIT_FAULT = 2;
  localparam int BIT_RSVD_LO = 3;
  localparam int BIT_CAP = 4;
  localparam int BIT_HOTSWAP = 5;
  localparam int BIT_MAIN_OK = 6;
  localparam int BIT_RSVD_HI = 7;
  // scaling of the readings, micro-units per lsb, for software only
  localparam int HOLDUP_UV_PER_LSB = 398000;
  localparam int CURRENT_UA_PER_LSB = 94000;
  localparam int FEED_UV_PER_LSB = 325000;
  // reset value of a measurement word
  localparam logic [7:0] READING_RESET = 8'h00;
  // bus link states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_PTR,
    ST_PTR_ACK,
    ST_WDATA,
    ST_WDATA_ACK,
    ST_RDATA,
    ST_RACK,
    ST_IGNORE
  } link_state_t;
endpackage : telemetry_pkg

// ---- logic/bit_sync.sv ----
// two-flop synchroniser for levels from another domain
module bit_sync
  import telemetry_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
)
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r; // first stage, read only by the second
  logic [WIDTH-1:0] sync_r; // second stage, safe to use

  // both stages freeze with the clock enable
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      meta_r <= RESET_VAL;
      sync_r <= RESET_VAL;
    end
    else if (i_ce)
    begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule : bit_sync

// ---- logic/telemetry_regmap.sv ----
// read-only byte map selected by the pointer, registered read data
module telemetry_regmap
  import telemetry_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [7:0] i_ptr,
  input wire logic [5:0] i_status_pins, // {main_ok,hotswap,cap,fault,feed_b,feed_a}
  input wire logic [7:0] i_holdup_voltage,
  input wire logic [7:0] i_output_current,
  input wire logic [7:0] i_feed_a_voltage,
  input wire logic [7:0] i_feed_b_voltage,
  input wire logic [7:0] i_module_heat_reading,
  output logic [7:0] o_rd_data
);
  wire [7:0] status_byte; // assembled status flags
  wire [7:0] rd_sel; // selected byte for the current pointer
  logic [7:0] rd_r; // registered read data

  // status layout, reserved bits forced low
  assign status_byte[BIT_FEED_A] = i_status_pins[0];
  assign status_byte[BIT_FEED_B] = i_status_pins[1];
  assign status_byte[BIT_FAULT] = i_status_pins[2];
  assign status_byte[BIT_RSVD_LO] = 1'b0;
  assign status_byte[BIT_CAP] = i_status_pins[3];
  assign status_byte[BIT_HOTSWAP] = i_status_pins[4];
  assign status_byte[BIT_MAIN_OK] = i_status_pins[5];
  assign status_byte[BIT_RSVD_HI] = 1'b0;

  // pointer decode; scaling stays with software, words pass unchanged
  assign rd_sel = (i_ptr == PTR_STATUS) ? status_byte :
                  (i_ptr == PTR_HOLDUP) ? i_holdup_voltage :
                  (i_ptr == PTR_CURRENT) ? i_output_current :
                  (i_ptr == PTR_FEED_A) ? i_feed_a_voltage :
                  (i_ptr == PTR_FEED_B) ? i_feed_b_voltage :
                  (i_ptr == PTR_HEAT) ? i_module_heat_reading :
                  UNMAPPED_DATA;

  // read data register follows the pointer every enabled cycle
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      rd_r <= UNMAPPED_DATA;
    else if (i_ce)
      rd_r <= rd_sel;
  end

  assign o_rd_data = rd_r;

  chk_status_layout: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_ptr == PTR_STATUS |=> o_rd_data == {1'b0, $past(i_status_pins[5:3]),
      1'b0, $past(i_status_pins[2:0])})
    else $error("status byte layout wrong");
  chk_feed_words: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_ptr == PTR_FEED_B |=> o_rd_data == $past(i_feed_b_voltage))
    else $error("feed b word not returned");
  chk_heat_word: assert property (@(posedge i_clk) disable iff (!i_resetn)
    i_ce && i_ptr == PTR_HEAT |=> o_rd_data == $past(i_module_heat_reading))
    else $error("heat word not returned");
endmodule : telemetry_regmap

// ---- verif/i2c_master_model.sv ----
// bus master model: drives the clock high and low, starts every transfer, only pulls sda low
module i2c_master_model
(
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_oe_n,
  output logic o_res_valid,
  output logic [7:0] o_res_val
);
  timeunit 1ns;
  timeprecision 100ps;
  // quarter of a bus bit in clocks, slow enough for the input synchronisers
  localparam int QTR = 15;
  // released lines at time zero, idle bus
  initial
  begin
    o_scl = 1'b1;
    o_sda_oe_n = 1'b1;
    o_res_valid = 1'b0;
    o_res_val = 8'h00;
  end
  // every change lands just after a rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : tick
  // one-cycle result strobe for the bench monitor
  task automatic report(input logic [7:0] v);
    o_res_val = v;
    o_res_valid = 1'b1;
    tick(1);
    o_res_valid = 1'b0;
  endtask : report
  // start, also used as repeated start from a low clock
  task automatic start_cond();
    o_sda_oe_n = 1'b1;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    o_sda_oe_n = 1'b0;
    tick(QTR);
    o_scl = 1'b0;
    tick(QTR);
  endtask : start_cond
  // stop: data rises while the clock is high
  task automatic stop_cond();
    o_sda_oe_n = 1'b0;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    o_sda_oe_n = 1'b1;
    tick(QTR);
  endtask : stop_cond
  // one bit: data held over the whole high phase, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    o_sda_oe_n = b;
    tick(QTR);
    o_scl = 1'b1;
    tick(QTR);
    r = i_sda;
    tick(QTR);
    o_scl = 1'b0;
    tick(QTR);
  endtask : bit_io
  // msb first, then the target's acknowledge is reported
  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    report({7'h00, r});
  endtask : send_byte
  // released data for eight bits, then our acknowledge or not
  task automatic recv_byte(input logic ack_bit);
    logic [7:0] v;
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
    bit_io(ack_bit, r);
    report(v);
  endtask : recv_byte
endmodule : i2c_master_model

// ---- verif/test_power_telemetry_i2c_slave.sv ----
`define CHECK_EQ(what, exp, got) \
  n_checks++; \
  if ((got) !== (exp)) \
  begin \
    num_errors++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end
// bench: master model on the bus, random readings and status pins
module test_power_telemetry_i2c_slave
  import telemetry_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, mclk, resetn, meas_resetn, scl, sda, dut_sda, dut_oe_n, m_oe_n;
  logic res_valid;
  logic [7:0] res_val, e_v;
  logic [2:0] strap;
  logic [5:0] pins; // {main_ok,hotswap,cap,fault,feed_b,feed_a}
  logic [7:0] rdg [5]; // holdup, current, feed a, feed b, heat
  logic [15:0] seed, ce_seed;
  logic ce; // clock enable of the bus domain, drops now and then
  logic [7:0] exp_q [$];
  string name_q [$];
  string e_n;
  int num_errors, n_checks;
  // wired-and line: pull-up, target pulls only when enabled (low)
  assign sda = m_oe_n & (dut_oe_n | dut_sda);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // measurement clock, unrelated phase
  initial
  begin
    mclk = 1'b0;
    #7;
    forever #24 mclk = ~mclk;
  end
  power_telemetry_i2c_slave u_dut (
    .i_clk(clk), .i_resetn(resetn), .i_ce(ce), .i_scl(scl),
    .i_serial_line_sda(sda), .o_serial_line_sda(dut_sda),
    .o_serial_line_sda_oe_n(dut_oe_n), .i_addr_strap(strap),
    .i_feed_a_on_input(pins[0]), .i_feed_b_on_input(pins[1]), .i_fault_alarm(pins[2]),
    .i_cap_connected(pins[3]), .i_hotswap_on(pins[4]), .i_main_output_ok(pins[5]),
    .i_meas_clk(mclk), .i_meas_resetn(meas_resetn), .i_holdup_voltage(rdg[0]),
    .i_output_current(rdg[1]), .i_feed_a_voltage(rdg[2]), .i_feed_b_voltage(rdg[3]),
    .i_module_heat_reading(rdg[4])
  );
  i2c_master_model u_master (
    .i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_oe_n(m_oe_n),
    .o_res_valid(res_valid), .o_res_val(res_val)
  );
  // sixteen-bit shift register for the random stream
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // clock enable drops for single cycles; the design must freeze, not lose bus edges
  always @(posedge clk)
  begin
    #1;
    ce_seed = lfsr(ce_seed);
    ce = (ce_seed[2:0] != 3'h0) || (ce === 1'b0);
  end
  task automatic rnd(output logic [7:0] v);
    seed = lfsr(seed);
    v = seed[7:0];
  endtask : rnd
  task automatic note(input string nm, input logic [7:0] v);
    name_q.push_back(nm);
    exp_q.push_back(v);
  endtask : note
  // pointer write, optional extra byte, repeated start, two reads of one register
  task automatic xfer(input logic [7:0] ptr, input logic [7:0] exp, input bit extra);
    logic [7:0] wa, x;
    wa = {ADDR_FIXED, strap, 1'b0};
    u_master.start_cond();
    note("addr_ack", 8'h00);
    u_master.send_byte(wa);
    note("ptr_ack", 8'h00);
    u_master.send_byte(ptr);
    if (extra)
    begin
      rnd(x);
      note("extra_ack", 8'h00);
      u_master.send_byte(x);
    end
    u_master.start_cond();
    note("raddr_ack", 8'h00);
    u_master.send_byte(wa | 8'h01);
    note("data_first", exp);
    u_master.recv_byte(1'b0);
    note("data_again", exp);
    u_master.recv_byte(1'b1);
    u_master.stop_cond();
  endtask : xfer
  // monitor: each result strobe takes the oldest note
  always @(posedge clk)
  begin
    if (res_valid === 1'b1)
    begin
      e_n = name_q.pop_front();
      e_v = exp_q.pop_front();
      `CHECK_EQ(e_n, e_v, res_val)
    end
  end
  task automatic end_sim();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim
  // watchdog: about 56k cycles of traffic are expected, the limit is 80k
  initial
  begin
    #800000;
    num_errors++;
    end_sim();
  end
  // main sequence
  initial
  begin
    logic [7:0] ptrs [7];
    logic [7:0] v, stat;
    // the last two entries: a pointer outside the map, then status again
    ptrs = '{PTR_HOLDUP, PTR_CURRENT, PTR_FEED_A, PTR_FEED_B, PTR_HEAT, 8'h20, PTR_STATUS};
    seed = 16'hF10B;
    ce_seed = 16'hF10B;
    resetn = 1'b0;
    meas_resetn = 1'b0;
    strap = 3'h0;
    pins = 6'h00;
    foreach (rdg[i]) rdg[i] = 8'h00;
    num_errors = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    #1;
    resetn = 1'b1;
    meas_resetn = 1'b1;
    u_master.tick(5);
    // every strap code: own write byte acked, a neighbour's refused
    for (int s = 0; s < 8; s++)
    begin
      strap = 3'(s);
      u_master.tick(10);
      u_master.start_cond();
      note("strap_ack", 8'h00);
      u_master.send_byte(8'h50 + {4'h0, strap, 1'b0});
      u_master.stop_cond();
      u_master.start_cond();
      note("foreign_nack", 8'h01);
      u_master.send_byte(8'h50 + {4'h0, strap + 3'h1, 1'b0});
      u_master.stop_cond();
    end
    // random readings and pins, status and one map entry per round
    for (int k = 0; k < 7; k++)
    begin
      foreach (rdg[i]) rnd(rdg[i]);
      rnd(v);
      pins = v[5:0];
      rnd(v);
      strap = v[2:0];
      u_master.tick(60);
      stat = {1'b0, pins[5:3], 1'b0, pins[2:0]};
      xfer(PTR_STATUS, stat, 1'b0);
      xfer(ptrs[k], (k < 5) ? rdg[k] : (k == 5) ? UNMAPPED_DATA : stat, k == 3);
    end
    // mid-run reset of both domains: pointer falls back to status, readings refill
    resetn = 1'b0;
    meas_resetn = 1'b0;
    u_master.tick(12);
    resetn = 1'b1;
    meas_resetn = 1'b1;
    u_master.tick(60);
    u_master.start_cond();
    note("reset_raddr_ack", 8'h00);
    u_master.send_byte({ADDR_FIXED, strap, 1'b1});
    note("reset_ptr_read", stat);
    u_master.recv_byte(1'b1);
    u_master.stop_cond();
    xfer(PTR_FEED_A, rdg[2], 1'b0);
    u_master.tick(10);
    `CHECK_EQ("pending_notes", 8'h00, 8'(exp_q.size()))
    end_sim();
  end
endmodule : test_power_telemetry_i2c_slave
